// [rtl/ivam_map.vh]
// Purpose: constants for the interrupt vector address map
// Assumes: word addresses into program memory, 16 bits wide
// Notes:   vector addresses are offsets from the table base
`ifndef IVAM_MAP_VH
`define IVAM_MAP_VH
`define IVAM_ADDR_W        16
`define IVAM_SRC_N         30
`define IVAM_RESET_VEC     16'h0000
`define IVAM_VEC_FIRST     16'h0002
`define IVAM_VEC_STEP      16'h0002
`define IVAM_VEC_LAST      16'h003C
`define IVAM_BOOT_TBL_OFS  16'h0002
`define IVAM_CHG_CYCLES    3'h4
`define IVAM_BOOT_RST_DEF  16'h0C00
`define IVAM_VEC_CMP0        16'h0002
`define IVAM_VEC_CMP1        16'h0004
`define IVAM_VEC_CMP2        16'h0006
`define IVAM_VEC_CMP3        16'h0008
`define IVAM_VEC_STAGE_FAULT 16'h000A
`define IVAM_VEC_STAGE_END   16'h000C
`define IVAM_VEC_EXT0        16'h000E
`define IVAM_VEC_EXT1        16'h0010
`define IVAM_VEC_EXT2        16'h0012
`define IVAM_VEC_EXT3        16'h0014
`define IVAM_VEC_T16_CAPT    16'h0016
`define IVAM_VEC_T16_CMPA    16'h0018
`define IVAM_VEC_T16_CMPB    16'h001A
`define IVAM_VEC_T16_OVF     16'h001C
`define IVAM_VEC_T8_CMPA     16'h001E
`define IVAM_VEC_T8_CMPB     16'h0020
`define IVAM_VEC_T8_OVF      16'h0022
`define IVAM_VEC_CAN_GEN     16'h0024
`define IVAM_VEC_CAN_OVF     16'h0026
`define IVAM_VEC_LIN_DONE    16'h0028
`define IVAM_VEC_LIN_ERR     16'h002A
`define IVAM_VEC_PCHG0       16'h002C
`define IVAM_VEC_PCHG1       16'h002E
`define IVAM_VEC_PCHG2       16'h0030
`define IVAM_VEC_PCHG3       16'h0032
`define IVAM_VEC_SPI_DONE    16'h0034
`define IVAM_VEC_ADC_DONE    16'h0036
`define IVAM_VEC_WDOG        16'h0038
`define IVAM_VEC_EE_RDY      16'h003A
`define IVAM_VEC_STORE_RDY   16'h003C
`endif

// [rtl/ivam_pick.v]
// Purpose: lowest-numbered pending source finder
// Assumes: req_i already gated with the global enable
// Notes:   purely combinational, registered by the parent
`timescale 1ns/1ps
`default_nettype none
`include "ivam_map.vh"
module ivam_pick (
   input  wire [`IVAM_SRC_N-1:0] req_i,
   output reg                    any_o,
   output reg  [4:0]             idx_o
);
   integer i;
   always @* begin
      any_o = 1'b0;
      idx_o = 5'h0;
      // scan from the top so the lowest index is written last
      for (i = `IVAM_SRC_N-1; i >= 0; i = i - 1) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = i[4:0];
         end
      end
   end
endmodule // ivam_pick
`default_nettype wire

// [rtl/ivam_top.v]
// Purpose: reset and interrupt vector address generation for the fetch unit
// Assumes: core writes the control byte through ctl_wr_i, one cycle per write
// Notes:   source bit n maps to vector n+2 (address 2n+2)
`timescale 1ns/1ps
`default_nettype none
`include "ivam_map.vh"
module ivam_top (
   input  wire                    core_clk_i,
   input  wire                    rst_n_i,
   input  wire                    boot_reset_fuse_i,
   input  wire [`IVAM_ADDR_W-1:0] boot_reset_addr_i,
   input  wire                    ctl_wr_i,
   input  wire                    ctl_vector_table_select_i,
   input  wire                    ctl_vector_change_enable_i,
   input  wire [`IVAM_SRC_N-1:0]  irq_req_i,
   input  wire                    global_irq_en_i,
   input  wire                    irq_ack_i,
   output reg                     reset_jump_o,
   output reg                     irq_valid_o,
   output reg  [4:0]              irq_idx_o,
   output reg  [`IVAM_ADDR_W-1:0] jump_addr_o,
   output reg                     vector_table_select_o,
   output reg                     vector_change_enable_o,
   output reg                     irq_blocked_o
);
   // ----------------------------------------------------------------
   // control byte: select and timed change enable
   // ----------------------------------------------------------------
   reg  [2:0] chg_cnt;
   reg        after_sel_wr;
   wire       sel_write = ctl_wr_i & vector_change_enable_o & ~ctl_vector_change_enable_i;
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         vector_table_select_o  <= 1'b0;
         vector_change_enable_o <= 1'b0;
         chg_cnt                <= 3'h0;
         after_sel_wr           <= 1'b0;
      end else begin
         after_sel_wr <= 1'b0;
         if (ctl_wr_i && ctl_vector_change_enable_i) begin
            // writing one restarts the window; select is not changed by it
            vector_change_enable_o <= 1'b1;
            chg_cnt                <= `IVAM_CHG_CYCLES;
         end else if (sel_write) begin
            vector_table_select_o  <= ctl_vector_table_select_i;
            vector_change_enable_o <= 1'b0;
            chg_cnt                <= 3'h0;
            // interrupts stay off for the instruction after the write
            after_sel_wr           <= 1'b1;
         end else if (vector_change_enable_o) begin
            if (chg_cnt == 3'h1) begin
               vector_change_enable_o <= 1'b0;
            end
            chg_cnt <= chg_cnt - 3'h1;
         end
      end
   end
   wire blocked = vector_change_enable_o | after_sel_wr |
                  (ctl_wr_i & ctl_vector_change_enable_i);

   // ----------------------------------------------------------------
   // fuse capture after reset release
   // ----------------------------------------------------------------
   reg                    in_reset;
   reg                    fuse_prog;
   reg [`IVAM_ADDR_W-1:0] boot_addr;
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         in_reset  <= 1'b1;
         fuse_prog <= 1'b0;
         boot_addr <= `IVAM_BOOT_RST_DEF;
      end else begin
         in_reset <= 1'b0;
         if (in_reset) begin
            fuse_prog <= ~boot_reset_fuse_i;  // fuse reads 0 when programmed
            boot_addr <= boot_reset_addr_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // vector selection
   // ----------------------------------------------------------------
   wire                    any;
   wire [4:0]              idx;
   wire [`IVAM_SRC_N-1:0]  gated = irq_req_i & {`IVAM_SRC_N{global_irq_en_i}};
   ivam_pick u_pick (
      .req_i (gated),
      .any_o (any),
      .idx_o (idx)
   );

   // ----------------------------------------------------------------
   // vector table: one entry per source, offset from the table base
   // ----------------------------------------------------------------
   reg [`IVAM_ADDR_W-1:0] tbl_ofs;
   always @* begin
      tbl_ofs = `IVAM_VEC_FIRST;
      case (idx)
         5'h00: tbl_ofs = `IVAM_VEC_CMP0;
         5'h01: tbl_ofs = `IVAM_VEC_CMP1;
         5'h02: tbl_ofs = `IVAM_VEC_CMP2;
         5'h03: tbl_ofs = `IVAM_VEC_CMP3;
         5'h04: tbl_ofs = `IVAM_VEC_STAGE_FAULT;
         5'h05: tbl_ofs = `IVAM_VEC_STAGE_END;
         5'h06: tbl_ofs = `IVAM_VEC_EXT0;
         5'h07: tbl_ofs = `IVAM_VEC_EXT1;
         5'h08: tbl_ofs = `IVAM_VEC_EXT2;
         5'h09: tbl_ofs = `IVAM_VEC_EXT3;
         5'h0A: tbl_ofs = `IVAM_VEC_T16_CAPT;
         5'h0B: tbl_ofs = `IVAM_VEC_T16_CMPA;
         5'h0C: tbl_ofs = `IVAM_VEC_T16_CMPB;
         5'h0D: tbl_ofs = `IVAM_VEC_T16_OVF;
         5'h0E: tbl_ofs = `IVAM_VEC_T8_CMPA;
         5'h0F: tbl_ofs = `IVAM_VEC_T8_CMPB;
         5'h10: tbl_ofs = `IVAM_VEC_T8_OVF;
         5'h11: tbl_ofs = `IVAM_VEC_CAN_GEN;
         5'h12: tbl_ofs = `IVAM_VEC_CAN_OVF;
         5'h13: tbl_ofs = `IVAM_VEC_LIN_DONE;
         5'h14: tbl_ofs = `IVAM_VEC_LIN_ERR;
         5'h15: tbl_ofs = `IVAM_VEC_PCHG0;
         5'h16: tbl_ofs = `IVAM_VEC_PCHG1;
         5'h17: tbl_ofs = `IVAM_VEC_PCHG2;
         5'h18: tbl_ofs = `IVAM_VEC_PCHG3;
         5'h19: tbl_ofs = `IVAM_VEC_SPI_DONE;
         5'h1A: tbl_ofs = `IVAM_VEC_ADC_DONE;
         5'h1B: tbl_ofs = `IVAM_VEC_WDOG;
         5'h1C: tbl_ofs = `IVAM_VEC_EE_RDY;
         5'h1D: tbl_ofs = `IVAM_VEC_STORE_RDY;
         // the finder never reports an index above the last source
         default: tbl_ofs = `IVAM_VEC_FIRST;
      endcase
   end
   // boot table starts at the boot reset address itself, vectors sit above that base
   wire [`IVAM_ADDR_W-1:0] tbl_base =
      vector_table_select_o ? boot_addr : `IVAM_RESET_VEC;
   wire [`IVAM_ADDR_W-1:0] rst_addr =
      fuse_prog ? boot_addr : `IVAM_RESET_VEC;

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reset_jump_o  <= 1'b0;
         irq_valid_o   <= 1'b0;
         irq_idx_o     <= 5'h0;
         jump_addr_o   <= `IVAM_RESET_VEC;
         irq_blocked_o <= 1'b0;
      end else begin
         irq_blocked_o <= blocked;
         reset_jump_o  <= in_reset;
         if (in_reset) begin
            // fuse is caught this edge, so use the pin value directly
            jump_addr_o <= boot_reset_fuse_i ? `IVAM_RESET_VEC : boot_reset_addr_i;
            irq_valid_o <= 1'b0;
         end else if (irq_valid_o) begin
            // offer stands until taken, then one idle cycle so the
            // source can drop its flag before it is looked at again
            irq_valid_o <= ~irq_ack_i;
         end else if (any && !blocked && !reset_jump_o) begin
            irq_valid_o <= 1'b1;
            irq_idx_o   <= idx;
            jump_addr_o <= tbl_base + tbl_ofs;
         end else begin
            irq_valid_o <= 1'b0;
            jump_addr_o <= rst_addr;
         end
      end
   end
endmodule // ivam_top
`default_nettype wire

// [verification/ivam_checker_assertions.sv]
// Purpose: port checks for ivam_top
// Assumes: boot_reset_addr_i steady; select not moved while an offer stands
// Notes:   bound at the foot
`timescale 1ns/1ps
`default_nettype none
module ivam_checker (
   input wire logic        core_clk_i, rst_n_i, boot_reset_fuse_i, irq_ack_i, irq_blocked_o,
   input wire logic        ctl_wr_i, ctl_vector_table_select_i, ctl_vector_change_enable_i,
   input wire logic        reset_jump_o, irq_valid_o, vector_table_select_o,
   input wire logic        vector_change_enable_o,
   input wire logic [15:0] boot_reset_addr_i, jump_addr_o,
   input wire logic [29:0] irq_req_i,
   input wire logic [4:0]  irq_idx_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   reset_entry_a: assert property ($rose(rst_n_i) |=> reset_jump_o && jump_addr_o ==
      (boot_reset_fuse_i ? 16'h0000 : boot_reset_addr_i)) else $error("reset entry");
   vector_addr_a: assert property (irq_valid_o |-> jump_addr_o == 16'h0002 +
      (vector_table_select_o ? boot_reset_addr_i : 16'h0000) + {irq_idx_o, 1'b0}) else $error("vector");
   lowest_wins_a: assert property ($rose(irq_valid_o) |-> (30'h1 << irq_idx_o) ==
      ($past(irq_req_i) & ((30'h2 << irq_idx_o) - 30'h1))) else $error("priority");
   offer_ack_a: assert property (irq_valid_o && irq_ack_i |=> !irq_valid_o) else $error("ack");
   change_arm_a: assert property (ctl_wr_i && ctl_vector_change_enable_i
      |=> vector_change_enable_o) else $error("arm");
   change_expire_a: assert property (ctl_wr_i && ctl_vector_change_enable_i ##1
      !ctl_wr_i [*4] |=> !vector_change_enable_o) else $error("expire");
   select_write_a: assert property (vector_change_enable_o && ctl_wr_i &&
      !ctl_vector_change_enable_i |=> !vector_change_enable_o &&
      vector_table_select_o == $past(ctl_vector_table_select_i)) else $error("select");
   select_lock_a: assert property (!vector_change_enable_o && ctl_wr_i
      |=> $stable(vector_table_select_o)) else $error("lock");
   irq_block_a: assert property (irq_blocked_o |-> !$rose(irq_valid_o)) else $error("blocked");
endmodule // ivam_checker
bind ivam_top ivam_checker i_ivam_checker (.*);
`default_nettype wire

// [verification/ivam_fetch_model.sv]
// Purpose: fetch unit stand-in that takes offered vectors
// Assumes: ack is a one-cycle pulse
// Notes:   wait_i sets how long an offer stands before it is taken
`timescale 1ns/1ps
`default_nettype none
module ivam_fetch_model (
   input  wire logic       core_clk_i,
   input  wire logic       valid_i,
   input  wire logic [3:0] wait_i,
   output var  logic       ack_o
);
   logic [3:0] cnt = 4'h0;
   initial ack_o = 1'b0;
   // never acks twice: the offer is still seen on the edge after the ack
   always @(posedge core_clk_i) begin
      ack_o <= valid_i && !ack_o && cnt >= wait_i;
      cnt   <= (valid_i && !ack_o) ? cnt + 4'h1 : 4'h0;
   end
endmodule // ivam_fetch_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for ivam_top
// Assumes: boot reset address fixed at 16'h0C00
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk_i = 1'b0, rst_n_i = 1'b0, fuse = 1'b1, gie = 1'b1;
   logic        wr = 1'b0, sel = 1'b0, ce = 1'b0;
   logic [29:0] req = 30'h0;
   logic [3:0]  lat = 4'h0;
   wire         ack, jmp, vld, sel_o, ce_o, blk;
   wire  [4:0]  idx;
   wire  [15:0] addr;
   int          mismatches = 0, compares = 0;
   always #4 core_clk_i = ~core_clk_i;
   ivam_top i_ivam_top (.core_clk_i, .rst_n_i, .boot_reset_fuse_i(fuse),
      .boot_reset_addr_i(16'h0C00), .ctl_wr_i(wr), .ctl_vector_table_select_i(sel),
      .ctl_vector_change_enable_i(ce), .irq_req_i(req), .global_irq_en_i(gie), .irq_ack_i(ack),
      .reset_jump_o(jmp), .irq_valid_o(vld), .irq_idx_o(idx), .jump_addr_o(addr),
      .vector_table_select_o(sel_o), .vector_change_enable_o(ce_o), .irq_blocked_o(blk));
   ivam_fetch_model i_ivam_fetch_model (.core_clk_i, .valid_i(vld), .wait_i(lat), .ack_o(ack));
   task close_out;
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [15:0] exp, got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tick; @(posedge core_clk_i); #1; endtask
   task write_ctl(input logic s, c);
      tick;
      {wr, sel, ce} = {1'b1, s, c};
      tick;
      wr = 1'b0;
   endtask
   // bounded so a lost request cannot hang the run
   task offer(input int n, input logic [15:0] base);
      int i;
      req[n] = 1'b1;
      for (i = 0; i < 20 && vld !== 1'b1; i++) tick;
      req = 30'h0;
      if (i == 20) begin
         mismatches++;
         close_out;
      end else begin
         chk("index", 16'(n), {11'h0, idx});
         chk("address", base + 16'(2 * n + 2), addr);
         for (i = 0; i < 20 && vld === 1'b1; i++) tick;
         if (i == 20) begin
            mismatches++;
            close_out;
         end
      end
   endtask
   task walk_table;
      for (int n = 0; n < 30; n++) offer(n, 16'h0000);
   endtask
   task lowest_first;
      req = 30'h2000_0000;
      offer(4, 16'h0000);
   endtask
   // masked requests are never offered; idle fetch address is the reset entry
   task masked_irq;
      gie = 1'b0;
      req[3] = 1'b1;
      repeat (4) tick;
      chk("masked", 16'h0000, {15'h0, vld});
      chk("idle address", 16'h0000, addr);
      gie = 1'b1;
      offer(3, 16'h0000);
   endtask
   task reset_entry(input logic f);
      {rst_n_i, fuse} = {1'b0, f};
      repeat (16) tick;
      rst_n_i = 1'b1;
      tick;
      chk("reset pulse", 16'h0001, {15'h0, jmp});
      chk("reset address", f ? 16'h0000 : 16'h0C00, addr);
   endtask
   task move_table;
      write_ctl(1'b1, 1'b0);
      chk("select locked", 16'h0000, {15'h0, sel_o});
      write_ctl(1'b0, 1'b1);
      write_ctl(1'b1, 1'b0);
      chk("select set", 16'h0001, {15'h0, sel_o});
      chk("enable cleared", 16'h0000, {15'h0, ce_o});
      lat = 4'h3;
      offer(29, 16'h0C00);
      write_ctl(1'b0, 1'b1);
      req[0] = 1'b1;
      repeat (3) tick;
      chk("blocked", 16'h0000, {15'h0, vld});
      chk("block flag", 16'h0001, {15'h0, blk});
      offer(0, 16'h0C00);
      chk("enable expired", 16'h0000, {15'h0, ce_o});
   endtask
   initial begin
      reset_entry(1'b0);
      reset_entry(1'b1);
      walk_table;
      lowest_first;
      masked_irq;
      move_table;
      close_out;
   end
endmodule // testbench
`default_nettype wire
